//--- verilog/apr_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef APR_DEFS_SVH
`define APR_DEFS_SVH
`define APR_OFS_CLK_SEL   8'h20
`define APR_OFS_ROUTE     8'h21
`define APR_OFS_MISC      8'h22
`define APR_OFS_RSV_A     8'h23
`define APR_OFS_RSV_B     8'h24
`define APR_OFS_FLAGS     8'h25
`define APR_REG_RESET     8'h00
`define APR_CLK_SEL_WMASK 8'h0d
`define APR_MISC_WMASK    8'h20
`define APR_B_BCLK_SEL    3
`define APR_B_WCLK_SEL    2
`define APR_B_DIN_SEL     0
`define APR_B_BCLK_OSRC   7
`define APR_B_SBCLK_OSRC  6
`define APR_F_WCLK_OSRC   5:4
`define APR_F_SWCLK_OSRC  3:2
`define APR_B_DOUT_LB     1
`define APR_B_SDOUT_SRC   0
`define APR_B_GC_EN       5
`define APR_WCLK_SEC      2'b10
`define APR_SWCLK_GEN     2'b01
`define APR_H_CMD         12'h000
`define APR_H_STAT        12'h004
`define APR_H_CTRL        12'h008
`define APR_H_WE_BIT      16
`define APR_PCLK_NS       8
`define APR_LINK_NS       80
`define APR_LINK_HALF     ((`APR_LINK_NS / `APR_PCLK_NS) / 2)
`define APR_WORD_BITS     16
`define APR_FIFO_DEPTH    32
`endif

//--- verilog/apr_pkg.sv
// Shared types of the audio port routing block.
package apr_pkg;
  typedef logic [7:0] apr_byte_t;
  typedef logic [1:0] apr_mux_t;
endpackage : apr_pkg

//--- verilog/apr_link_if.sv
// Wires between the host audio port and the routing device.
`timescale 1ns/1ps
interface apr_link_if;
  import apr_pkg::*;
  logic      host_bclk;
  logic      host_wclk;
  logic      host_din;
  logic      gpio;
  logic      sclk;
  logic      miso;
  logic      dev_bclk;
  logic      dev_bclk_oe;
  logic      dev_wclk;
  logic      dev_wclk_oe;
  logic      dev_dout;
  logic      dev_sec_bclk;
  logic      dev_sec_wclk;
  logic      dev_sec_dout;
  logic      reg_req;
  logic      reg_we;
  apr_byte_t reg_addr;
  apr_byte_t reg_wdata;
  logic      reg_ack;
  apr_byte_t reg_rdata;
  logic      bclk;
  logic      wclk;
  // Shared clock wires: the device wins while it drives.
  assign bclk = dev_bclk_oe ? dev_bclk : host_bclk;
  assign wclk = dev_wclk_oe ? dev_wclk : host_wclk;
  modport dev (input bclk, wclk, host_din, gpio, sclk, miso, reg_req,
               reg_we, reg_addr, reg_wdata,
               output dev_bclk, dev_bclk_oe, dev_wclk, dev_wclk_oe,
               dev_dout, dev_sec_bclk, dev_sec_wclk, dev_sec_dout,
               reg_ack, reg_rdata);
  modport hst (input bclk, wclk, dev_dout, dev_sec_dout, reg_ack,
               reg_rdata,
               output host_bclk, host_wclk, host_din, gpio, sclk, miso,
               reg_req, reg_we, reg_addr, reg_wdata);
endinterface : apr_link_if

//--- verilog/apr_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module apr_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import apr_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } apr_fifo_s;
  apr_fifo_s r, n;
  logic push, pop;

  // Full and empty come straight from the stored count.
  assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update.
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : apr_fifo

//--- verilog/apr_dev.sv
// Routing device end: clock and data selection, loopback, flags.
// How it works
// - Bit clock select picks primary or secondary.
// - Word clock select picks primary or secondary.
// - Data input select picks primary or secondary.
// - Primary bit-clock out: generated or secondary.
// - Secondary bit-clock out: primary input or generated.
// - Primary word-clock out: 00 generated, 10 secondary.
// - Secondary word-clock out: 00 primary, 01 generated.
// - Primary data-out loops back secondary data input.
// - Secondary data-out loops back primary data input.
// - General call accepted only while enable set.
// - Converter power flag mirrors converter power.
// - Headphone power flag mirrors driver power.
// - Reserved registers and flag bits read zero.
// - Reserved select bits keep reset value.
// - Secondary clock mux: gpio, sclk, miso, dout.
// - Bit-clock pin driven only when direction set.
`timescale 1ns/1ps
`include "apr_defs.svh"
module apr_dev #(
  parameter int W        = `APR_WORD_BITS,
  parameter int DEPTH    = `APR_FIFO_DEPTH,
  parameter int GEN_HALF = `APR_LINK_HALF
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  apr_link_if.dev              ln,
  input  wire logic            bclk_dir,
  input  wire logic            wclk_dir,
  input  wire apr_pkg::apr_mux_t sec_bclk_mux,
  input  wire apr_pkg::apr_mux_t sec_wclk_mux,
  input  wire logic            sec_din_mux,
  input  wire logic            dac_powered,
  input  wire logic            hp_powered,
  input  wire logic            gc_addr_seen,
  output logic                 gc_accept,
  output logic                 rx_overrun,
  output logic                 rx_valid,
  input  wire logic            rx_ready,
  output logic [W-1:0]         rx_data
);
  import apr_pkg::*;
  typedef struct packed {
    logic [5:0]  s1;
    logic [5:0]  s2;
    logic [1:0]  p1;
    logic [1:0]  p2;
    apr_byte_t   clk_sel;
    apr_byte_t   route;
    apr_byte_t   misc;
    logic        ack;
    apr_byte_t   rdata;
    logic [7:0]  gen_cnt;
    logic        gen_bclk;
    logic [7:0]  gen_bits;
    logic        gen_fs;
    logic        bprev;
    logic        wprev;
    logic [W-1:0] sh;
    logic        push;
    logic [W-1:0] pdata;
    logic        ovr;
    logic        bclk_o;
    logic        bclk_oe;
    logic        wclk_o;
    logic        wclk_oe;
    logic        dout_o;
    logic        sbclk_o;
    logic        swclk_o;
    logic        sdout_o;
    logic        gc_acc;
  } apr_dev_s;
  apr_dev_s r, n;
  logic fifo_rdy;
  logic sbclk_in, swclk_in, sdin, bsel, wsel, dsel;

  // One bit out of the four secondary pin sources.
  function automatic logic apr_pick4(input apr_mux_t sel,
                                     input logic [3:0] v);
    return v[sel];
  endfunction : apr_pick4

  // Register read map; unused and reserved bits read as zero.
  function automatic apr_byte_t apr_rd(input apr_byte_t a,
                                       input apr_dev_s s);
    apr_byte_t d;
    d = `APR_REG_RESET;
    case (a)
      `APR_OFS_CLK_SEL: d = s.clk_sel;
      `APR_OFS_ROUTE:   d = s.route;
      `APR_OFS_MISC:    d = s.misc;
      `APR_OFS_FLAGS:   d = {s.p2[1], 1'b0, s.p2[0], 5'h00};
      default:          d = `APR_REG_RESET;
    endcase
    return d;
  endfunction : apr_rd

  // Pin order in s1/s2: bclk, wclk, din, gpio, sclk, miso.
  always_comb begin
    sbclk_in = apr_pick4(sec_bclk_mux,
                         {r.dout_o, r.s2[0], r.s2[1], r.s2[2]});
    swclk_in = apr_pick4(sec_wclk_mux,
                         {r.dout_o, r.s2[0], r.s2[1], r.s2[2]});
    sdin = sec_din_mux ? r.s2[1] : r.s2[2];
    bsel = r.clk_sel[`APR_B_BCLK_SEL] ? sbclk_in : r.s2[5];
    wsel = r.clk_sel[`APR_B_WCLK_SEL] ? swclk_in : r.s2[4];
    dsel = r.clk_sel[`APR_B_DIN_SEL] ? sdin : r.s2[3];
  end

  // Next-state logic of the whole device.
  always_comb begin
    n = r;
    n.s1 = {ln.bclk, ln.wclk, ln.host_din, ln.gpio, ln.sclk, ln.miso};
    n.s2 = r.s1;
    n.p1 = {dac_powered, hp_powered};
    n.p2 = r.p1;
    // Register port: one ack pulse per request.
    n.ack = ln.reg_req & ~r.ack;
    if (ln.reg_req && !r.ack) begin
      n.rdata = apr_rd(ln.reg_addr, r);
      if (ln.reg_we) begin
        case (ln.reg_addr)
          `APR_OFS_CLK_SEL:
            n.clk_sel = ln.reg_wdata & `APR_CLK_SEL_WMASK;
          `APR_OFS_ROUTE: n.route = ln.reg_wdata;
          `APR_OFS_MISC:
            n.misc = ln.reg_wdata & `APR_MISC_WMASK;
          default: n.misc = r.misc;
        endcase
      end
    end
    // Internal bit clock and sample-rate clock generator.
    if (r.gen_cnt == 8'(GEN_HALF - 1)) begin
      n.gen_cnt  = 8'h00;
      n.gen_bclk = ~r.gen_bclk;
      if (r.gen_bclk) begin
        if (r.gen_bits == 8'(W - 1)) begin
          n.gen_bits = 8'h00;
          n.gen_fs   = ~r.gen_fs;
        end else begin
          n.gen_bits = r.gen_bits + 8'h01;
        end
      end
    end else begin
      n.gen_cnt = r.gen_cnt + 8'h01;
    end
    // Deserialiser: a word edge at a rising bit clock ends a word.
    n.push  = 1'b0;
    n.bprev = bsel;
    if (bsel && !r.bprev) begin
      n.wprev = wsel;
      n.sh    = {r.sh[W-2:0], dsel};
      if (wsel != r.wprev) begin
        n.push  = 1'b1;
        n.pdata = r.sh;
      end
    end
    n.ovr = r.push & ~fifo_rdy;
    n.bclk_oe = bclk_dir;
    n.wclk_oe = wclk_dir;
    n.bclk_o = r.route[`APR_B_BCLK_OSRC] ? sbclk_in : r.gen_bclk;
    n.sbclk_o = r.route[`APR_B_SBCLK_OSRC] ? r.gen_bclk : r.s2[5];
    // forbidden codes fall back to generated.
    n.wclk_o = (r.route[`APR_F_WCLK_OSRC] == `APR_WCLK_SEC) ?
               swclk_in : r.gen_fs;
    // reserved codes fall back to primary.
    n.swclk_o = (r.route[`APR_F_SWCLK_OSRC] == `APR_SWCLK_GEN) ?
                r.gen_fs : r.s2[4];
    n.dout_o = r.route[`APR_B_DOUT_LB] ? sdin : 1'b0;
    n.sdout_o = r.route[`APR_B_SDOUT_SRC] ? 1'b0 : r.s2[3];
    n.gc_acc = gc_addr_seen & r.misc[`APR_B_GC_EN];
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Receive buffer between the serial port and the user side.
  apr_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (r.push),
    .in_ready  (fifo_rdy),
    .in_data   (r.pdata),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Outputs straight from the state register.
  assign ln.dev_bclk     = r.bclk_o;
  assign ln.dev_bclk_oe  = r.bclk_oe;
  assign ln.dev_wclk     = r.wclk_o;
  assign ln.dev_wclk_oe  = r.wclk_oe;
  assign ln.dev_dout     = r.dout_o;
  assign ln.dev_sec_bclk = r.sbclk_o;
  assign ln.dev_sec_wclk = r.swclk_o;
  assign ln.dev_sec_dout = r.sdout_o;
  assign ln.reg_ack      = r.ack;
  assign ln.reg_rdata    = r.rdata;
  assign gc_accept       = r.gc_acc;
  assign rx_overrun      = r.ovr;
endmodule : apr_dev

//--- verilog/apr_host.sv
// Host end: APB command registers, register port master, serial out.
`timescale 1ns/1ps
`include "apr_defs.svh"
module apr_host #(
  parameter int W    = `APR_WORD_BITS,
  parameter int HALF = `APR_LINK_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [W-1:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [2:0]  aux_pins,
  apr_link_if.hst          ln
);
  import apr_pkg::*;
  typedef struct packed {
    logic        busy;
    logic        req;
    logic        we;
    apr_byte_t   addr;
    apr_byte_t   wdata;
    apr_byte_t   rdata;
    logic        en;
    logic [7:0]  cnt;
    logic        bclk;
    logic        wclk;
    logic        din;
    logic [7:0]  bits;
    logic [W-1:0] sh;
    logic        txr;
    logic        prdy;
    logic [31:0] prd;
    logic        perr;
    logic [2:0]  aux;
  } apr_host_s;
  apr_host_s r, n;
  logic acc;

  // Access edge of an APB transfer.
  assign acc = psel & penable & r.prdy;

  // Next-state logic.
  always_comb begin
    n = r;
    n.aux = aux_pins;
    // Setup phase: answer is prepared so pready rises in access.
    n.prdy = psel & ~penable;
    // Error is raised only in the cycle beside pready, straight from a flop.
    n.perr = 1'b0;
    if (psel && !penable) begin
      n.prd  = 32'h0000_0000;
      case (paddr)
        `APR_H_CMD:  n.prd = {15'h0000, r.we, r.wdata, r.addr};
        `APR_H_STAT: n.prd = {16'h0000, r.rdata, 7'h00, r.busy};
        `APR_H_CTRL: n.prd = {31'h0000_0000, r.en};
        default:     n.perr = 1'b1;
      endcase
    end
    // Writes take effect at the access edge; a busy command is kept.
    if (acc && pwrite) begin
      if (paddr == `APR_H_CMD && !r.busy) begin
        n.busy  = 1'b1;
        n.req   = 1'b1;
        n.addr  = pwdata[7:0];
        n.wdata = pwdata[15:8];
        n.we    = pwdata[`APR_H_WE_BIT];
      end else if (paddr == `APR_H_CTRL) begin
        n.en = pwdata[0];
      end
    end
    // Device register port completes on the ack pulse.
    if (r.req && ln.reg_ack) begin
      n.req   = 1'b0;
      n.busy  = 1'b0;
      n.rdata = ln.reg_rdata;
    end
    // Link clock divider and left-justified serialiser.
    n.txr = 1'b0;
    if (r.en) begin
      if (r.cnt == 8'(HALF - 1)) begin
        n.cnt  = 8'h00;
        n.bclk = ~r.bclk;
        if (r.bclk) begin
          if (r.bits == 8'h00) begin
            n.wclk = ~r.wclk;
            n.din  = (tx_valid & r.txr) ? tx_data[W-1] : 1'b0;
            n.sh   = (tx_valid & r.txr) ? {tx_data[W-2:0], 1'b0} : '0;
          end else begin
            n.din = r.sh[W-1];
            n.sh  = {r.sh[W-2:0], 1'b0};
          end
          n.bits = (r.bits == 8'(W - 1)) ? 8'h00 : r.bits + 8'h01;
        end
      end else begin
        n.cnt = r.cnt + 8'h01;
        n.txr = (r.cnt == 8'(HALF - 2)) & r.bclk & (r.bits == 8'h00);
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register.
  assign prdata       = r.prd;
  assign pready       = r.prdy;
  assign pslverr      = r.perr;
  assign tx_ready     = r.txr;
  assign ln.host_bclk = r.bclk;
  assign ln.host_wclk = r.wclk;
  assign ln.host_din  = r.din;
  assign ln.gpio      = r.aux[0];
  assign ln.sclk      = r.aux[1];
  assign ln.miso      = r.aux[2];
  assign ln.reg_req   = r.req;
  assign ln.reg_we    = r.we;
  assign ln.reg_addr  = r.addr;
  assign ln.reg_wdata = r.wdata;
endmodule : apr_host

//--- bench/apr_link_monitor.sv
// Assertions on the link between the host end and the device end.
`timescale 1ns/1ps
`include "apr_defs.svh"
module apr_link_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               host_din,
  input wire logic               bclk,
  input wire logic               wclk,
  input wire logic               dev_dout,
  input wire logic               dev_sec_bclk,
  input wire logic               dev_sec_wclk,
  input wire logic               dev_sec_dout,
  input wire logic               reg_req,
  input wire logic               reg_we,
  input wire apr_pkg::apr_byte_t reg_addr,
  input wire apr_pkg::apr_byte_t reg_wdata,
  input wire logic               reg_ack,
  input wire apr_pkg::apr_byte_t reg_rdata
);
  import apr_pkg::*;
  apr_byte_t  sh_r [3];
  apr_byte_t  rsv_m;
  logic [3:0] age_r;
  logic       rd_ok;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bits that must read zero at the addressed register.
  always_comb begin
    case (reg_addr)
      `APR_OFS_CLK_SEL: rsv_m = ~`APR_CLK_SEL_WMASK;
      `APR_OFS_ROUTE:   rsv_m = 8'h00;
      `APR_OFS_MISC:    rsv_m = ~`APR_MISC_WMASK;
      `APR_OFS_FLAGS:   rsv_m = 8'h5f;
      default:          rsv_m = 8'hff;
    endcase
  end
  // The three writable registers sit at the first three offsets.
  assign rd_ok = reg_addr[7:2] == 6'h08 && reg_addr[1:0] != 2'b11;
  // Shadow of the writable registers and cycles since the last write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r  <= '{default: 8'h00};
      age_r <= 4'h0;
    end else if (reg_ack && reg_we) begin
      age_r <= 4'h0;
      if (rd_ok) begin
        sh_r[reg_addr[1:0]] <= reg_wdata & ~rsv_m;
      end
    end else if (age_r != 4'hf) begin
      age_r <= age_r + 4'h1;
    end
  end
  property p_ack_prompt;
    reg_req && !reg_ack |=> reg_ack;
  endproperty
  a_ack_prompt: assert property (p_ack_prompt)
    else $error("register request not answered in one cycle");
  property p_ack_pulse;
    reg_ack |=> !reg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("register answer longer than one cycle");
  property p_ack_cause;
    reg_ack |-> $past(reg_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("register answer without a request");
  property p_rsv_bits;
    reg_ack && !reg_we |-> (reg_rdata & rsv_m) == 8'h00;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits)
    else $error("reserved bits read nonzero");
  property p_readback;
    reg_ack && !reg_we && rd_ok |-> reg_rdata == sh_r[reg_addr[1:0]];
  endproperty
  a_readback: assert property (p_readback)
    else $error("register read differs from last write");
  property p_sec_bclk;
    $stable(bclk)[*4] ##0 (!sh_r[1][6] && age_r > 4'h4)
      |-> dev_sec_bclk == bclk;
  endproperty
  a_sec_bclk: assert property (p_sec_bclk)
    else $error("secondary bit clock does not follow bit clock");
  property p_sec_wclk;
    $stable(wclk)[*4] ##0 (sh_r[1][3:2] == 2'b00 && age_r > 4'h4)
      |-> dev_sec_wclk == wclk;
  endproperty
  a_sec_wclk: assert property (p_sec_wclk)
    else $error("secondary word clock does not follow word clock");
  property p_sec_dout;
    $stable(host_din)[*4] ##0 (!sh_r[1][0] && age_r > 4'h4)
      |-> dev_sec_dout == host_din;
  endproperty
  a_sec_dout: assert property (p_sec_dout)
    else $error("secondary data out does not loop back data in");
  property p_dout_rsv;
    !sh_r[1][1] && age_r > 4'h2 |-> !dev_dout;
  endproperty
  a_dout_rsv: assert property (p_dout_rsv)
    else $error("data out active with loopback off");
  c_route_wr: cover property (reg_ack && reg_we && reg_addr == 8'h21);
  c_flag_rd: cover property (reg_ack && !reg_we && reg_rdata[7]);
  c_dout_lb: cover property (sh_r[1][1] && dev_dout);
endmodule : apr_link_monitor

//--- bench/audio_port_clock_data_routing_bench.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
`include "apr_defs.svh"
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module audio_port_clock_data_routing_bench;
  import apr_pkg::*;
  localparam apr_byte_t WM [6] = '{8'h0d, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [15:0] tx_data, rx_data, ew;
  logic        tx_valid, tx_ready, wclk_dir, dac_powered, hp_powered, pw;
  logic        bclk_dir, sec_din_mux, pb;
  logic        gc_addr_seen, gc_accept, rx_overrun, rx_valid, rx_ready;
  logic [2:0]  aux_pins;
  apr_mux_t    sec_wclk_mux, sec_bclk_mux;
  apr_byte_t   eb, eq;
  apr_byte_t   rq[$];
  logic [15:0] sq[$];
  int          err_total, compares, cyc, ovr, nall, n, nb;
  apr_link_if  ln ();
  apr_host u_apr_host (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .aux_pins(aux_pins),
    .ln(ln));
  apr_dev u_apr_dev (
    .pclk(pclk), .presetn(presetn), .ln(ln), .bclk_dir(bclk_dir),
    .wclk_dir(wclk_dir), .sec_bclk_mux(sec_bclk_mux),
    .sec_wclk_mux(sec_wclk_mux), .sec_din_mux(sec_din_mux),
    .dac_powered(dac_powered), .hp_powered(hp_powered),
    .gc_addr_seen(gc_addr_seen), .gc_accept(gc_accept),
    .rx_overrun(rx_overrun), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data));
  apr_link_monitor u_apr_link_monitor (
    .pclk(pclk), .presetn(presetn), .host_din(ln.host_din),
    .bclk(ln.bclk), .wclk(ln.wclk), .dev_dout(ln.dev_dout),
    .dev_sec_bclk(ln.dev_sec_bclk), .dev_sec_wclk(ln.dev_sec_wclk),
    .dev_sec_dout(ln.dev_sec_dout), .reg_req(ln.reg_req),
    .reg_we(ln.reg_we), .reg_addr(ln.reg_addr), .reg_wdata(ln.reg_wdata),
    .reg_ack(ln.reg_ack), .reg_rdata(ln.reg_rdata));
  // Clock at 125 MHz.
  initial begin
    pclk = 1'b0;
    forever #(`APR_PCLK_NS / 2) pclk = ~pclk;
  end
  // A hang is cut short and counted as a mismatch.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end
  // Register read data against the oldest noted value.
  always @(posedge pclk) begin
    if (ln.reg_ack === 1'b1 && ln.reg_we === 1'b0 && rq.size() > 0) begin
      eq = rq.pop_front();
      `CHK("reg_rdata", eq, ln.reg_rdata)
    end
  end
  // Received words against the oldest word sent; idle zeros are skipped.
  always @(posedge pclk) begin
    if (rx_overrun === 1'b1) ovr++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      nall++;
      if (rx_data !== 16'h0000 && sq.size() > 0) begin
        ew = sq.pop_front();
        `CHK("rx_data", ew, rx_data)
      end
    end
  end
  // A word is taken at the edge where the ready pulse is seen.
  always @(posedge pclk) begin
    if (tx_ready === 1'b1 && tx_valid === 1'b1) begin
      sq.push_back(tx_data);
      tx_data <= 16'($urandom) | 16'h0001;
    end
  end
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One device register access through the command register.
  task automatic dev_op(input logic w, input apr_byte_t a,
                        input apr_byte_t d);
    int k;
    apb(`APR_H_CMD, 1'b1, {15'h0000, w, d, a});
    k = 0;
    while (ln.reg_ack !== 1'b1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    do begin
      apb(`APR_H_STAT, 1'b0, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 80);
  endtask : dev_op
  // Counts, verdict and end of run.
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  initial begin
    {psel, penable, pwrite, tx_valid, wclk_dir, dac_powered} = '0;
    {hp_powered, gc_addr_seen, rx_ready, presetn} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_data = 16'h0001;
    aux_pins = 3'b000;
    sec_wclk_mux = 2'b00;
    sec_bclk_mux = 2'b00;
    bclk_dir = 1'b0;
    sec_din_mux = 1'b0;
    void'($urandom(32'h871c4c40));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rq.push_back(8'h00);
      dev_op(1'b0, 8'(8'h20 + i), 8'h00);
      if (i != 1) dev_op(1'b1, 8'(8'h20 + i), 8'hff);
      rq.push_back(WM[i]);
      dev_op(1'b0, 8'(8'h20 + i), 8'h00);
    end
    dev_op(1'b1, `APR_OFS_CLK_SEL, 8'h00);
    apb(12'h00c, 1'b0, 32'h0);
    `CHK("pslverr", 1'b1, perr)
    $display("register map test done");
    for (int g = 1; g >= 0; g--) begin
      @(posedge pclk);
      gc_addr_seen <= 1'b1;
      @(posedge pclk);
      gc_addr_seen <= 1'b0;
      @(posedge pclk);
      `CHK("gc_accept", 1'(g), gc_accept)
      dev_op(1'b1, `APR_OFS_MISC, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      eb = {r[7:5], 2'b00, r[2], 2'b10};
      dev_op(1'b1, `APR_OFS_ROUTE, eb);
      rq.push_back(eb);
      dev_op(1'b0, `APR_OFS_ROUTE, 8'h00);
      dac_powered <= i[1];
      hp_powered <= i[0];
      repeat (4) @(posedge pclk);
      rq.push_back({i[1], 1'b0, i[0], 5'h00});
      dev_op(1'b0, `APR_OFS_FLAGS, 8'h00);
      `CHK("stat_rdata", {i[1], 1'b0, i[0], 5'h00}, rd[15:8])
    end
    $display("routing and flag test done");
    // Both clock pins driven by the device from the secondary sources.
    wclk_dir <= 1'b1;
    bclk_dir <= 1'b1;
    dev_op(1'b1, `APR_OFS_ROUTE, 8'ha2);
    for (int m = 0; m < 4; m++) begin
      sec_wclk_mux <= apr_mux_t'(m);
      sec_bclk_mux <= apr_mux_t'(m);
      // Code 11 takes the data-out loopback, fed here from sclk.
      sec_din_mux <= (m == 3);
      for (int v = 1; v >= 0; v--) begin
        aux_pins <= 3'(v << ((m == 3) ? 1 : m));
        repeat (8) @(posedge pclk);
        `CHK("wclk", 1'(v), ln.wclk)
        `CHK("bclk", 1'(v), ln.bclk)
      end
    end
    dev_op(1'b1, `APR_OFS_ROUTE, 8'h02);
    pw = ln.wclk;
    pb = ln.bclk;
    n = 0;
    nb = 0;
    repeat (400) begin
      @(posedge pclk);
      if (ln.wclk !== pw) n++;
      if (ln.bclk !== pb) nb++;
      pw = ln.wclk;
      pb = ln.bclk;
    end
    `CHK("fs_toggles", 1'b1, n >= 2 && n <= 3)
    `CHK("gen_bclk_toggles", 1'b1, nb >= 79 && nb <= 81)
    wclk_dir <= 1'b0;
    bclk_dir <= 1'b0;
    $display("word clock source test done");
    tx_valid <= 1'b1;
    apb(`APR_H_CTRL, 1'b1, 32'h1);
    n = 0;
    while (ovr == 0 && n < 8000) begin
      @(posedge pclk);
      n++;
    end
    apb(`APR_H_CTRL, 1'b1, 32'h0);
    tx_valid <= 1'b0;
    repeat (300) begin
      @(posedge pclk);
      rx_ready <= 1'($urandom);
    end
    rx_ready <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("rx_count", 32, nall)
    `CHK("rx_valid", 1'b0, rx_valid)
    `CHK("overrun", 1'b1, ovr > 0)
    $display("stream test done");
    end_sim();
  end
endmodule : audio_port_clock_data_routing_bench
